// ---- rtl/pfrc_flash_read_ctrl.sv ----
// Program flash access control: address, data and control registers on
// AXI4-Lite, plus the sequencer that steals one instruction slot per read.
// Assumes instr_tick pulses on the last clock of each core instruction cycle
// and the flash array answers a read within the stolen slot.
//
// Operation
// - Data high byte keeps six word bits low; bits 7-6 read zero.
// - Address high byte keeps four address bits low; bits 7-4 read zero.
// - Control bit 7 reads one; control bits 5-3 read zero.
// - Calibration select one steers reads to test area, zero to user area.
// - Write enable one permits flash writes; zero blocks every write.
// - Write trigger starts a write; software sets only, hardware clears.
// - Write trigger reads zero whenever no write is running.
// - Read trigger starts a read; hardware clears it; zero writes ignored.
// - Second instruction after the trigger is dropped; its slot reads flash.
// - First instruction after the trigger runs normally.
// - Fetched word shows in both data bytes right after the stolen slot.
// - Data bytes hold until next read or a software write.
// - Writes attempted with calibration select set are suppressed.
// - Write enable is clear after reset.
// - Flash space is 4k words; low address byte gives bits 7-0.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module pfrc_flash_read_ctrl
  import pfrc_pkg::*;
#(
  parameter int unsigned AXI_AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instr_tick,
  output logic fetch_stall_strobe,
  output logic [PFRC_NVM_AW-1:0] nvm_addr,
  output logic nvm_calib_select,
  output logic nvm_read_strobe,
  input wire logic [PFRC_WORD_W-1:0] nvm_read_data,
  output logic nvm_write_req,
  output logic [PFRC_WORD_W-1:0] nvm_write_data,
  input wire logic nvm_write_done
);

  // ****************************************
  // Parameter checks
  // ****************************************

  // Refuse a bus address too narrow for the register map
  if (AXI_AW < 8) begin : g_bad_axi_aw
    $error("bus address width must be at least 8");
  end

  // Flash address is the high bits over a full low byte
  if (PFRC_NVM_AW != PFRC_HI_ADDR_W + 8) begin : g_bad_nvm_aw
    $error("flash address width must be the high bits plus eight");
  end

  // Flash word is the high data bits over a full low byte
  if (PFRC_WORD_W != PFRC_HI_DATA_W + 8) begin : g_bad_word_w
    $error("flash word width must be the high data bits plus eight");
  end

  // ****************************************
  // Address decode
  // ****************************************

  // Map a byte address onto a register selector
  function automatic pfrc_sel_t pfrc_decode(input logic [7:0] addr);
    pfrc_sel_t sel;
    sel = PFRC_SEL_NONE;
    unique case (addr)
      PFRC_OFF_CTRL: sel = PFRC_SEL_CTRL;
      PFRC_OFF_ADDR_LO: sel = PFRC_SEL_ADDR_LO;
      PFRC_OFF_ADDR_HI: sel = PFRC_SEL_ADDR_HI;
      PFRC_OFF_DATA_LO: sel = PFRC_SEL_DATA_LO;
      PFRC_OFF_DATA_HI: sel = PFRC_SEL_DATA_HI;
      default: sel = PFRC_SEL_NONE;
    endcase
    return sel;
  endfunction

  // ****************************************
  // Trigger gates
  // ****************************************

  // Write start: trigger with enable set and calibration space off
  function automatic logic pfrc_write_gate(input logic [7:0] wbyte, input logic busy);
    logic go;
    go = wbyte[PFRC_CTRL_WR_BIT] && wbyte[PFRC_CTRL_PROGRAM_ENABLE_GATE_BIT];
    return go && !wbyte[PFRC_CTRL_CALIB_SPACE_SELECT_BIT] && !busy;
  endfunction

  // Read start: trigger while idle and no write starting with it
  function automatic logic pfrc_read_gate(input logic [7:0] wbyte, input logic busy,
    input logic write_start);
    return wbyte[PFRC_CTRL_RD_BIT] && !busy && !write_start;
  endfunction

  // ****************************************
  // State
  // ****************************************

  typedef struct packed {
    logic calib_space_select;
    logic program_enable_gate;
    logic wr;
    logic rd;
    logic [7:0] addr_lo;
    logic [PFRC_HI_ADDR_W-1:0] addr_hi;
    pfrc_rd_state_t rd_state;
    logic read_strobe;
    logic stall;
    logic write_req;
  } pfrc_state_t;

  localparam pfrc_state_t PFRC_STATE_RST = '{
    calib_space_select: 1'b0,
    program_enable_gate: 1'b0,
    wr: 1'b0,
    rd: 1'b0,
    addr_lo: PFRC_BYTE_RST,
    addr_hi: '0,
    rd_state: PFRC_IDLE,
    read_strobe: 1'b0,
    stall: 1'b0,
    write_req: 1'b0
  };

  pfrc_state_t q, d;

  pfrc_reg_if regs ();

  logic [PFRC_WORD_W-1:0] word;
  logic load_flash;
  logic sw_we_low;
  logic sw_we_high;
  pfrc_sel_t wr_sel;
  pfrc_sel_t rd_sel;
  logic [7:0] ctrl_view;

  // ****************************************
  // Bus slave and data word
  // ****************************************

  pfrc_axil_slave #(
    .AW(AXI_AW)
  ) u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regs.bus_side)
  );

  pfrc_word_hold u_word (
    .aclk(aclk),
    .aresetn(aresetn),
    .load_flash(load_flash),
    .flash_word(nvm_read_data),
    .sw_we_low(sw_we_low),
    .sw_we_high(sw_we_high),
    .sw_byte(regs.wr_byte),
    .word(word)
  );

  // Decoded selectors for both directions
  assign wr_sel = pfrc_decode(regs.wr_addr);
  assign rd_sel = pfrc_decode(regs.rd_addr);
  assign regs.wr_err = (wr_sel == PFRC_SEL_NONE);
  assign regs.rd_err = (rd_sel == PFRC_SEL_NONE);

  // Software writes into the data bytes
  assign sw_we_low = regs.wr_en && (wr_sel == PFRC_SEL_DATA_LO);
  assign sw_we_high = regs.wr_en && (wr_sel == PFRC_SEL_DATA_HI);

  // Word captured at the close of the stolen slot
  assign load_flash = (q.rd_state == PFRC_STEAL) && instr_tick;

  // ****************************************
  // Read view of the registers
  // ****************************************

  // Control byte with fixed one on top and fixed zeros in the middle
  always_comb begin
    ctrl_view = 8'h80;
    ctrl_view[PFRC_CTRL_CALIB_SPACE_SELECT_BIT] = q.calib_space_select;
    ctrl_view[PFRC_CTRL_PROGRAM_ENABLE_GATE_BIT] = q.program_enable_gate;
    ctrl_view[PFRC_CTRL_WR_BIT] = q.wr;
    ctrl_view[PFRC_CTRL_RD_BIT] = q.rd;
  end

  // Read data mux, upper bits zero
  always_comb begin
    regs.rd_data = '0;
    unique case (rd_sel)
      PFRC_SEL_CTRL: regs.rd_data[7:0] = ctrl_view;
      PFRC_SEL_ADDR_LO: regs.rd_data[7:0] = q.addr_lo;
      PFRC_SEL_ADDR_HI: regs.rd_data[PFRC_HI_ADDR_W-1:0] = q.addr_hi;
      PFRC_SEL_DATA_LO: regs.rd_data[7:0] = word[7:0];
      PFRC_SEL_DATA_HI: regs.rd_data[PFRC_HI_DATA_W-1:0] = word[PFRC_WORD_W-1:8];
      PFRC_SEL_NONE: regs.rd_data = '0;
      default: regs.rd_data = '0;
    endcase
  end

  // ****************************************
  // Register writes and sequencing
  // ****************************************

  // Next state of control, address and the read slot sequencer
  always_comb begin
    logic start_rd;
    logic start_wr;
    logic ctrl_we;
    d = q;
    ctrl_we = regs.wr_en && (wr_sel == PFRC_SEL_CTRL);
    start_rd = 1'b0;
    start_wr = 1'b0;

    // Address bytes; only implemented bits are stored
    if (regs.wr_en && (wr_sel == PFRC_SEL_ADDR_LO)) begin
      d.addr_lo = regs.wr_byte;
    end
    if (regs.wr_en && (wr_sel == PFRC_SEL_ADDR_HI)) begin
      d.addr_hi = regs.wr_byte[PFRC_HI_ADDR_W-1:0];
    end

    // Control byte; bits 7 and 5-3 are dropped
    if (ctrl_we) begin
      d.calib_space_select = regs.wr_byte[PFRC_CTRL_CALIB_SPACE_SELECT_BIT];
      d.program_enable_gate = regs.wr_byte[PFRC_CTRL_PROGRAM_ENABLE_GATE_BIT];
      // Write only with enable set and calibration space off
      start_wr = pfrc_write_gate(regs.wr_byte, q.wr || q.rd);
      // Zero written to the trigger has no effect; a starting write wins
      start_rd = pfrc_read_gate(regs.wr_byte, q.wr || q.rd, start_wr);
    end

    // Write cycle held until the array reports completion
    if (q.wr && nvm_write_done) begin
      d.wr = 1'b0;
      d.write_req = 1'b0;
    end
    if (start_wr) begin
      d.wr = 1'b1;
      d.write_req = 1'b1;
    end

    // Read slot sequencer
    unique case (q.rd_state)
      PFRC_IDLE: begin
        if (start_rd) begin
          d.rd = 1'b1;
          // A tick in the setting cycle ends the setting instruction
          d.rd_state = instr_tick ? PFRC_SKIP : PFRC_ARMED;
        end
      end
      PFRC_ARMED: begin
        if (instr_tick) begin
          d.rd_state = PFRC_SKIP;
        end
      end
      PFRC_SKIP: begin
        // Following instruction runs, then its slot ends
        if (instr_tick) begin
          d.rd_state = PFRC_STEAL;
          d.stall = 1'b1;
          d.read_strobe = 1'b1;
        end
      end
      PFRC_STEAL: begin
        // Array word taken at the close of the stolen slot
        if (instr_tick) begin
          d.rd_state = PFRC_IDLE;
          d.stall = 1'b0;
          d.read_strobe = 1'b0;
          d.rd = 1'b0;
        end
      end
      default: begin
        // Illegal code: release the slot and return to idle
        d.rd_state = PFRC_IDLE;
        d.stall = 1'b0;
        d.read_strobe = 1'b0;
        d.rd = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= PFRC_STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Flash side outputs
  // ****************************************

  // Address held from software; reads rely on both bytes loaded first
  assign nvm_addr = {q.addr_hi, q.addr_lo};
  assign nvm_calib_select = q.calib_space_select;

  // Read slot strobes, both high through the stolen slot
  assign nvm_read_strobe = q.read_strobe;
  assign fetch_stall_strobe = q.stall;

  // Write request and the word it programs
  assign nvm_write_req = q.write_req;
  assign nvm_write_data = word;

endmodule

// ---- rtl/pfrc_pkg.sv ----
// Shared constants and types of the program flash read control block.
// Assumes a byte-wide register model placed in the low lane of 32-bit words.
package pfrc_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] PFRC_OFF_CTRL = 8'h00;
  localparam logic [7:0] PFRC_OFF_ADDR_LO = 8'h04;
  localparam logic [7:0] PFRC_OFF_ADDR_HI = 8'h08;
  localparam logic [7:0] PFRC_OFF_DATA_LO = 8'h0C;
  localparam logic [7:0] PFRC_OFF_DATA_HI = 8'h10;

  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int unsigned PFRC_BUS_DW = 32;
  localparam int unsigned PFRC_WORD_W = 14;
  localparam int unsigned PFRC_NVM_AW = 12;
  localparam int unsigned PFRC_HI_DATA_W = 6;
  localparam int unsigned PFRC_HI_ADDR_W = 4;
  localparam int unsigned PFRC_CTRL_RD_BIT = 0;
  localparam int unsigned PFRC_CTRL_WR_BIT = 1;
  localparam int unsigned PFRC_CTRL_PROGRAM_ENABLE_GATE_BIT = 2;
  localparam int unsigned PFRC_CTRL_CALIB_SPACE_SELECT_BIT = 6;

  // ****************************************
  // Reset values and responses
  // ****************************************
  localparam logic [7:0] PFRC_BYTE_RST = 8'h00;
  localparam logic [1:0] PFRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFRC_RESP_SLVERR = 2'h2;

  // Register selector returned by the address decoder
  typedef enum logic [2:0] {
    PFRC_SEL_NONE = 3'h0,
    PFRC_SEL_CTRL = 3'h1,
    PFRC_SEL_ADDR_LO = 3'h2,
    PFRC_SEL_ADDR_HI = 3'h3,
    PFRC_SEL_DATA_LO = 3'h4,
    PFRC_SEL_DATA_HI = 3'h5
  } pfrc_sel_t;

  // Read slot sequencer, one-hot
  typedef enum logic [3:0] {
    PFRC_IDLE = 4'h1,
    PFRC_ARMED = 4'h2,
    PFRC_SKIP = 4'h4,
    PFRC_STEAL = 4'h8
  } pfrc_rd_state_t;

endpackage

// ---- rtl/pfrc_reg_if.sv ----
// Internal register access path between the bus slave and the register file.
// Assumes both ends run on the same clock; all strobes are one-cycle pulses.
`timescale 1ns/1ns
interface pfrc_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;

  modport bus_side (output wr_en, output wr_addr, output wr_byte, output rd_addr,
    input wr_err, input rd_data, input rd_err);
  modport reg_side (input wr_en, input wr_addr, input wr_byte, input rd_addr,
    output wr_err, output rd_data, output rd_err);
endinterface

// ---- rtl/pfrc_axil_slave.sv ----
// AXI4-Lite slave that turns bus transfers into byte register accesses.
// Assumes one outstanding write and one outstanding read; low lane only.
`timescale 1ns/1ns
module pfrc_axil_slave
  import pfrc_pkg::*;
#(
  parameter int unsigned AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  pfrc_reg_if.bus_side regs
);

  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic lane0;
    logic [7:0] addr;
    logic [7:0] wbyte;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } pfrc_axs_t;

  pfrc_axs_t q, d;

  if (AW < 8) begin : g_bad_aw
    $error("address width must be at least 8");
  end

  // Register access strobes
  assign regs.wr_en = q.aw_held & q.w_held & ~q.bvalid & q.lane0;
  assign regs.wr_addr = q.addr;
  assign regs.wr_byte = q.wbyte;
  assign regs.rd_addr = s_axi_araddr[7:0];

  // Next state of both channels
  always_comb begin
    d = q;
    if (s_axi_awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.wbyte = s_axi_wdata[7:0];
      d.lane0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = regs.wr_err ? PFRC_RESP_SLVERR : PFRC_RESP_OKAY;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = regs.rd_data;
      d.rresp = regs.rd_err ? PFRC_RESP_SLVERR : PFRC_RESP_OKAY;
    end
    d.awready = ~d.aw_held & ~d.bvalid;
    d.wready = ~d.w_held & ~d.bvalid;
    d.arready = ~d.rvalid;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;

endmodule

// ---- rtl/pfrc_word_hold.sv ----
// Holds the 14-bit flash data word, loaded from the array or by software.
// Assumes load strobes are one-cycle pulses on the common clock.
`timescale 1ns/1ns
module pfrc_word_hold
  import pfrc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load_flash,
  input wire logic [PFRC_WORD_W-1:0] flash_word,
  input wire logic sw_we_low,
  input wire logic sw_we_high,
  input wire logic [7:0] sw_byte,
  output logic [PFRC_WORD_W-1:0] word
);

  typedef struct packed {
    logic [PFRC_WORD_W-1:0] word;
  } pfrc_hold_t;

  pfrc_hold_t q, d;

  // Flash load wins over a software byte write
  always_comb begin
    d = q;
    if (load_flash) begin
      d.word = flash_word;
    end else if (sw_we_low) begin
      d.word[7:0] = sw_byte;
    end else if (sw_we_high) begin
      d.word[PFRC_WORD_W-1:8] = sw_byte[PFRC_HI_DATA_W-1:0];
    end
  end

  // Word register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign word = q.word;

endmodule

// ---- test/pfrc_flash_model.sv ----
// Behavioural program flash array on the far side of the control block.
// Assumes strobes from the control block on the common clock.
`timescale 1ns/1ns
module pfrc_flash_model
  import pfrc_pkg::*;
#(
  parameter int unsigned WLAT = 30
) (
  input wire logic aclk,
  input wire logic [PFRC_NVM_AW-1:0] nvm_addr,
  input wire logic nvm_calib_select,
  input wire logic nvm_read_strobe,
  output logic [PFRC_WORD_W-1:0] nvm_read_data,
  input wire logic nvm_write_req,
  output logic nvm_write_done = 1'b0
);
  logic [PFRC_WORD_W-1:0] word;
  int wcnt = 0;

  // Word of the calibration or the user area, 4k words each
  assign word = nvm_calib_select ? {2'h1, ~nvm_addr} : {2'h2, nvm_addr};
  // Lines show the inverse outside a read slot
  assign nvm_read_data = nvm_read_strobe ? word : ~word;

  // Write finishes after a fixed latency
  always @(posedge aclk) begin
    wcnt <= (nvm_write_req && !nvm_write_done) ? wcnt + 1 : 0;
    nvm_write_done <= nvm_write_req && wcnt == WLAT - 1;
  end
endmodule

// ---- test/pfrc_properties.sv ----
// Port assertions of the flash read control top.
// Assumes one clock domain and a one-cycle instruction tick.
`timescale 1ns/1ns
module pfrc_chk
  import pfrc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_tick,
  input wire logic fetch_stall_strobe,
  input wire logic nvm_read_strobe,
  input wire logic nvm_write_req,
  input wire logic nvm_write_done,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  // ********
  // Clocking
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ********
  // Read slot
  // ********
  a_stall_pair: assert property (fetch_stall_strobe == nvm_read_strobe)
    else $error("stall and read strobe differ");
  a_stall_rise_tick: assert property ($rose(fetch_stall_strobe) |-> $past(instr_tick))
    else $error("stall began off an instruction boundary");
  a_stall_fall_tick: assert property ($fell(fetch_stall_strobe) |-> $past(instr_tick))
    else $error("stall ended off an instruction boundary");
  a_stall_holds: assert property (fetch_stall_strobe && !instr_tick |=> fetch_stall_strobe)
    else $error("stall dropped inside the slot");

  // ********
  // Write cycle
  // ********
  a_write_holds: assert property (nvm_write_req && !nvm_write_done |=> nvm_write_req)
    else $error("write request dropped early");
  a_write_clears: assert property (nvm_write_req && nvm_write_done |=> !nvm_write_req)
    else $error("write request outlived done");
  a_no_overlap: assert property (!(nvm_write_req && nvm_read_strobe))
    else $error("read slot during a write");

  // ********
  // Bus
  // ********
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule

bind pfrc_flash_read_ctrl pfrc_chk u_chk (
  .aclk,
  .aresetn,
  .instr_tick,
  .fetch_stall_strobe,
  .nvm_read_strobe,
  .nvm_write_req,
  .nvm_write_done,
  .s_axi_rvalid,
  .s_axi_rdata
);

// ---- test/program_flash_read_control_tb.sv ----
// Self-checking bench of the program flash read control block.
// Assumes the flash model as far side and a four-clock instruction cycle.
`timescale 1ns/1ns
module program_flash_read_control_tb
  import pfrc_pkg::*;
;
  localparam logic [1:0] OK = PFRC_RESP_OKAY;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [7:0] e;
    logic [1:0] r;
  } pfrc_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, instr_tick = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, tcnt = 2'h0;
  logic fetch_stall_strobe, nvm_calib_select, nvm_read_strobe, nvm_write_req, nvm_write_done;
  logic [PFRC_NVM_AW-1:0] nvm_addr;
  logic [PFRC_WORD_W-1:0] nvm_read_data, nvm_write_data;
  int fail_count = 0, comparisons = 0;
  // Address, written word, expected byte, response
  pfrc_row_t rows [7] = '{
    '{8'h08, 32'hFFFF_FFFF, 8'h0F, OK},
    '{8'h04, 32'h1234_56A5, 8'hA5, OK},
    '{8'h10, 32'hFFFF_FFFF, 8'h3F, OK},
    '{8'h0C, 32'h0000_005A, 8'h5A, OK},
    '{8'h00, 32'h0000_00B8, 8'h80, OK},
    '{8'h00, 32'h0000_0044, 8'hC4, OK},
    '{8'h14, 32'h0000_00FF, 8'h00, PFRC_RESP_SLVERR}
  };

  pfrc_flash_read_ctrl uut (.*);
  pfrc_flash_model #(.WLAT(30)) u_flash (.*);

  // ********
  // Clock and instruction tick
  // ********
  initial begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    tcnt <= tcnt + 2'h1;
    instr_tick <= (tcnt == 2'h2);
  end

  // ********
  // Tasks
  // ********
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 100) begin
      fail_count++;
      $display("wrong value at %0t: wait ran out", $time);
      end_sim();
    end
  endtask
  // Bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid || s_axi_wvalid) && n < 100);
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    tmo(n);
    chk(s_axi_bresp, er);
  endtask
  // Bus read and compare of the whole data word, upper three bytes zero
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    tmo(n);
    chk(s_axi_rdata, {24'h0, e});
    chk(s_axi_rresp, er);
  endtask
  // Flash read: address first, then trigger, then one stolen slot
  task automatic flash_read(input logic [11:0] a, input logic c);
    logic [13:0] w;
    int n;
    w = c ? {2'h1, ~a} : {2'h2, a};
    wr(8'h08, {28'h0, a[11:8]}, OK);
    wr(8'h04, {24'h0, a[7:0]}, OK);
    wr(8'h00, {25'h0, c, 6'h01}, OK);
    n = 0;
    while (fetch_stall_strobe !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    chk(nvm_addr, a);
    chk(nvm_calib_select, c);
    n = 0;
    while (fetch_stall_strobe === 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(n, 4);
    rd(8'h0C, w[7:0], OK);
    rd(8'h10, {2'h0, w[13:8]}, OK);
    rd(8'h00, {1'b1, c, 6'h00}, OK);
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    int n;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].r);
      rd(rows[i].a, rows[i].e, rows[i].r);
    end
    $display("test register table done");
    wr(8'h0C, 32'h96, OK);
    wr(8'h10, 32'h2B, OK);
    wr(8'h00, 32'h07, OK);
    chk(nvm_write_req, 1'b1);
    chk(nvm_write_data, 14'h2B96);
    rd(8'h00, 8'h86, OK);
    wr(8'h00, 32'h05, OK);
    rd(8'h00, 8'h86, OK);
    n = 0;
    while (nvm_write_req === 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    rd(8'h00, 8'h84, OK);
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, i ? 32'h46 : 32'h02, OK);
      chk(nvm_write_req, 1'b0);
      rd(8'h00, i ? 8'hC4 : 8'h80, OK);
    end
    $display("test write cycle done");
    flash_read(12'h3C5, 1'b0);
    s_axi_wstrb <= 4'h0;
    wr(8'h04, 32'h0, OK);
    s_axi_wstrb <= 4'h1;
    rd(8'h04, 8'hC5, OK);
    wr(8'h04, 32'h0, OK);
    rd(8'h0C, 8'hC5, OK);
    flash_read(12'hFFF, 1'b1);
    $display("test flash read done");
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4), i ? 8'h00 : 8'h80, OK);
    end
    $display("test reset values done");
    end_sim();
  end
endmodule
